// File: logic/uml_consts.svh
/*
 * Register indices, field positions and reset values of the modem-line
 * and interrupt block. Assumes inclusion by bare name from logic files.
 */
`ifndef UML_CONSTS_SVH
`define UML_CONSTS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define UML_IDX_INT_STAT   3'h0
`define UML_IDX_INT_EN     3'h1
`define UML_IDX_INT_CLR    3'h2
`define UML_IDX_CTRL       3'h3
`define UML_IDX_MCR        3'h4
`define UML_IDX_MSR        3'h6

// ****************************************
// Field positions
// ****************************************
`define UML_CTRL_FIFO_BIT  0
`define UML_CTRL_ACTS_BIT  1
`define UML_MCR_DTR_BIT    0
`define UML_MCR_LOOP_BIT   4
`define UML_SRC_RXERR      0
`define UML_SRC_RXDATA     1
`define UML_SRC_THRE       2
`define UML_SRC_MODEM      3

// ****************************************
// Reset values and responses
// ****************************************
`define UML_RST_CTRL       2'h0
`define UML_RST_MCR        8'h00
`define UML_RST_INT        4'h0
`define UML_RST_PIN        4'hF
`define UML_RESP_OKAY      2'h0
`define UML_RESP_SLVERR    2'h2

`endif

// File: logic/uml_pkg.sv
/*
 * Types shared by the modem-line and interrupt block.
 * Assumes uml_consts.svh supplies the numeric constants.
 */
package uml_pkg;
   typedef logic [2:0] uml_idx_t;
   typedef logic [1:0] uml_resp_t;
   typedef logic [3:0] uml_src_t;
   typedef logic [3:0] uml_lines_t;
endpackage

// File: logic/uml_sync.sv
/*
 * Two-stage synchroniser, one chain per line.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "uml_consts.svh"

module uml_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             rst,
   // Lines
   input  wire logic [WIDTH-1:0] din,
   output      logic [WIDTH-1:0] dout
);
   import uml_pkg::*;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_line
         logic meta_r;
         logic sync_r;
         // Idle pins sit high, so reset to the inactive level
         always_ff @(posedge aclk) begin
            if (rst) begin
               meta_r <= 1'h1;
               sync_r <= 1'h1;
            end else begin
               meta_r <= din[g];
               sync_r <= meta_r;
            end
         end
         assign dout[g] = sync_r;
      end
   endgenerate
endmodule

// File: logic/uml_irq.sv
/*
 * Sticky interrupt status, enable mask and write-only clear.
 * Assumes the caller gives one-cycle write strobes and event pulses.
 */
`timescale 1ns/100ps
`include "uml_consts.svh"

module uml_irq #(
   parameter int NSRC = 4
) (
   // Clock and reset
   input  wire logic            aclk,
   input  wire logic            rst,
   // Events and register writes
   input  wire logic [NSRC-1:0] evt,
   input  wire logic            en_wr,
   input  wire logic            clr_wr,
   input  wire logic [NSRC-1:0] wdata,
   // State and output
   output      logic [NSRC-1:0] stat_r,
   output      logic [NSRC-1:0] en_r,
   output      logic            irq
);
   import uml_pkg::*;

   logic [NSRC-1:0] stat_nxt;

   // A new event beats a clear landing in the same cycle
   always_comb begin
      stat_nxt = clr_wr ? (stat_r & ~wdata) : stat_r;
      stat_nxt = stat_nxt | evt;
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         stat_r <= NSRC'(`UML_RST_INT);
      end else begin
         stat_r <= stat_nxt;
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         en_r <= NSRC'(`UML_RST_INT);
      end else if (en_wr) begin
         en_r <= wdata;
      end
   end

   assign irq = |(stat_r & en_r);

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (rst);

   a_irq_raise: assert property ((|(evt & en_r)) && !en_wr |=> irq)
      else $error("irq not raised by enabled event");
   a_irq_service: assert property (clr_wr && (wdata == '1) && (evt == '0) && !en_wr
                                  |=> !irq)
      else $error("irq still high after full service");
endmodule

// File: logic/uml_top.sv
/*
 * Modem status lines, DTR output, transmit gating and interrupt output
 * of an async comm element, with registers reached over AXI4-Lite.
 * Assumes one 200 MHz clock; modem pins arrive asynchronously.
 */
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
// Behaviour
// - Register select chooses the accessed register
// - Bus accesses act only while selected
// - Status bits 4,5,7 show CTS,DSR,DCD
// - Bits 0,1,3 flag CTS,DSR,DCD changes
// - DSR or DCD change interrupts when enabled
// - CTS change interrupts unless auto gating
// - Auto gating lets CTS hold transmitter
// - DTR output low when control bit set
// - DTR high after reset, loopback, clear
// - Interrupt output high while service pending
// - Four interrupt source classes drive output
// - Interrupt drops on service and reset
// - Eight-bit data path, undriven when idle (rdata here is always driven, bits 31:8 zero)
// - Ring level bit 6, trailing edge bit 2
// - Master reset clears registers, forces outputs
`timescale 1ns/100ps
`include "uml_consts.svh"

module uml_top #(
   parameter int AW = 8
) (
   // Clock and resets
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             master_reset_input,
   // Chip select
   input  wire logic             chip_select_active_low,
   // AXI4-Lite write address
   input  wire logic [AW-1:0]    awaddr,
   input  wire logic             awvalid,
   output      logic             awready,
   // AXI4-Lite write data
   input  wire logic [31:0]      wdata,
   input  wire logic [3:0]       wstrb,
   input  wire logic             wvalid,
   output      logic             wready,
   // AXI4-Lite write response
   output      uml_pkg::uml_resp_t bresp,
   output      logic             bvalid,
   input  wire logic             bready,
   // AXI4-Lite read address
   input  wire logic [AW-1:0]    araddr,
   input  wire logic             arvalid,
   output      logic             arready,
   // AXI4-Lite read data
   output      logic [31:0]      rdata,
   output      uml_pkg::uml_resp_t rresp,
   output      logic             rvalid,
   input  wire logic             rready,
   // Modem pins, active low
   input  wire logic             cts_n,
   input  wire logic             dsr_n,
   input  wire logic             ri_n,
   input  wire logic             dcd_n,
   output      logic             dtr_n,
   // Receiver and transmitter events
   input  wire logic             rx_error_evt,
   input  wire logic             rx_data_evt,
   input  wire logic             rx_timeout_evt,
   input  wire logic             thr_empty_evt,
   // Transmitter gate and interrupt
   output      logic             tx_allowed,
   output      logic             interrupt_request_output
);
   import uml_pkg::*;

   // ****************************************
   // Reset and decoding
   // ****************************************
   logic rst;
   assign rst = !aresetn || master_reset_input;

   // Only the low five address bits select; anything above is unmapped
   function automatic logic is_mapped(input logic [AW-1:0] addr);
      uml_idx_t idx;
      idx = addr[4:2];
      is_mapped = (addr[AW-1:5] == '0) && (idx != 3'h5) && (idx != 3'h7);
   endfunction

   // ****************************************
   // Modem line synchronisation
   // ****************************************
   uml_lines_t pins_sync;
   uml_lines_t lvl;
   uml_lines_t prev_r;
   uml_lines_t delta_r;
   uml_lines_t delta_set;
   uml_lines_t delta_nxt;
   logic       msr_rd;

   uml_sync #(
      .WIDTH (4)
   ) u_sync (
      .aclk (aclk),
      .rst  (rst),
      .din  ({dcd_n, ri_n, dsr_n, cts_n}),
      .dout (pins_sync)
   );

   // Active-high levels: bit 0 CTS, 1 DSR, 2 RI, 3 DCD
   assign lvl = ~pins_sync;

   always_ff @(posedge aclk) begin
      if (rst) begin
         prev_r <= ~uml_lines_t'(`UML_RST_PIN);
      end else begin
         prev_r <= lvl;
      end
   end

   always_comb begin
      delta_set[0] = lvl[0] ^ prev_r[0];
      delta_set[1] = lvl[1] ^ prev_r[1];
      delta_set[2] = prev_r[2] && !lvl[2];
      delta_set[3] = lvl[3] ^ prev_r[3];
      // A change in the read cycle survives into the next read
      delta_nxt = (msr_rd ? 4'h0 : delta_r) | delta_set;
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         delta_r <= 4'h0;
      end else begin
         delta_r <= delta_nxt;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   logic [7:0] mcr_r;
   logic [1:0] ctrl_r;
   logic       wr_fire;
   logic       wr_ok;
   uml_idx_t   wr_idx;
   logic [AW-1:0] awaddr_r;
   logic [31:0]   wdata_r;
   logic [3:0]    wstrb_r;
   logic          aw_got_r;
   logic          w_got_r;
   logic          bvalid_r;
   uml_resp_t     bresp_r;
   logic          auto_cts;
   logic          loop_mode;

   assign wr_idx  = awaddr_r[4:2];
   assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
   assign wr_ok   = wr_fire && !chip_select_active_low && is_mapped(awaddr_r)
                    && wstrb_r[0];

   always_ff @(posedge aclk) begin
      if (rst) begin
         mcr_r <= `UML_RST_MCR;
      end else if (wr_ok && wr_idx == `UML_IDX_MCR) begin
         mcr_r <= wdata_r[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         ctrl_r <= `UML_RST_CTRL;
      end else if (wr_ok && wr_idx == `UML_IDX_CTRL) begin
         ctrl_r <= wdata_r[1:0];
      end
   end

   assign auto_cts  = ctrl_r[`UML_CTRL_ACTS_BIT];
   assign loop_mode = mcr_r[`UML_MCR_LOOP_BIT];

   // Loopback keeps the far end from seeing a ready terminal
   assign dtr_n = !(mcr_r[`UML_MCR_DTR_BIT] && !loop_mode);
   assign tx_allowed = !auto_cts || lvl[0];

   // ****************************************
   // Interrupt sources
   // ****************************************
   uml_src_t evt;
   uml_src_t int_stat;
   uml_src_t int_en;
   logic     modem_evt;

   assign modem_evt = delta_set[1] || delta_set[2] || delta_set[3]
                      || (delta_set[0] && !auto_cts);

   always_comb begin
      evt = 4'h0;
      evt[`UML_SRC_RXERR]  = rx_error_evt;
      evt[`UML_SRC_RXDATA] = rx_data_evt
                             || (rx_timeout_evt && ctrl_r[`UML_CTRL_FIFO_BIT]);
      evt[`UML_SRC_THRE]   = thr_empty_evt;
      evt[`UML_SRC_MODEM]  = modem_evt;
   end

   uml_irq #(
      .NSRC (4)
   ) u_irq (
      .aclk   (aclk),
      .rst    (rst),
      .evt    (evt),
      .en_wr  (wr_ok && wr_idx == `UML_IDX_INT_EN),
      .clr_wr (wr_ok && wr_idx == `UML_IDX_INT_CLR),
      .wdata  (wdata_r[3:0]),
      .stat_r (int_stat),
      .en_r   (int_en),
      .irq    (interrupt_request_output)
   );

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   assign awready = !aw_got_r && !bvalid_r;
   assign wready  = !w_got_r && !bvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;

   always_ff @(posedge aclk) begin
      if (rst) begin
         aw_got_r <= 1'h0;
         awaddr_r <= '0;
      end else if (awvalid && awready) begin
         aw_got_r <= 1'h1;
         awaddr_r <= awaddr;
      end else if (wr_fire) begin
         aw_got_r <= 1'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         w_got_r <= 1'h0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end else if (wvalid && wready) begin
         w_got_r <= 1'h1;
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end else if (wr_fire) begin
         w_got_r <= 1'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         bvalid_r <= 1'h0;
         bresp_r  <= `UML_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'h1;
         bresp_r  <= (!chip_select_active_low && is_mapped(awaddr_r))
                     ? `UML_RESP_OKAY : `UML_RESP_SLVERR;
      end else if (bready) begin
         bvalid_r <= 1'h0;
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   logic       rvalid_r;
   logic [7:0] rdata_r;
   uml_resp_t  rresp_r;
   logic       rd_fire;
   logic       rd_ok;
   uml_idx_t   rd_idx;
   logic [7:0] rd_byte;

   assign arready = !rvalid_r;
   assign rd_fire = arvalid && arready;
   assign rd_idx  = araddr[4:2];
   assign rd_ok   = rd_fire && !chip_select_active_low && is_mapped(araddr);
   assign msr_rd  = rd_ok && rd_idx == `UML_IDX_MSR;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = {24'h000000, rdata_r};

   always_comb begin
      case (rd_idx)
         `UML_IDX_INT_STAT: rd_byte = {4'h0, int_stat};
         `UML_IDX_INT_EN:   rd_byte = {4'h0, int_en};
         `UML_IDX_CTRL:     rd_byte = {6'h00, ctrl_r};
         `UML_IDX_MCR:      rd_byte = mcr_r;
         `UML_IDX_MSR:      rd_byte = {lvl[3], lvl[2], lvl[1], lvl[0], delta_r};
         default:           rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         rvalid_r <= 1'h0;
         rdata_r  <= 8'h00;
         rresp_r  <= `UML_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_r <= 1'h1;
         rdata_r  <= rd_ok ? rd_byte : 8'h00;
         rresp_r  <= rd_ok ? `UML_RESP_OKAY : `UML_RESP_SLVERR;
      end else if (rready) begin
         rvalid_r <= 1'h0;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (rst);

   sequence s_msr_read;
      msr_rd && delta_set == 4'h0;
   endsequence

   sequence s_quiet_lines;
      delta_set == 4'h0;
   endsequence

   a_msr_levels: assert property (msr_rd |=> rdata[4] == $past(lvl[0])
                                  && rdata[5] == $past(lvl[1]) && rdata[7] == $past(lvl[3]))
      else $error("status levels wrong in read data");
   a_cts_delta: assert property ($changed(lvl[0]) |=> delta_r[0])
      else $error("clear-to-send change not flagged");
   a_dcd_delta: assert property ($changed(lvl[3]) |=> delta_r[3])
      else $error("carrier change not flagged");
   a_ri_trail: assert property ($fell(lvl[2]) |=> delta_r[2])
      else $error("ring trailing edge not flagged");
   a_delta_clear: assert property (s_msr_read ##1 s_quiet_lines |-> delta_r == 4'h0)
      else $error("change flags survive status read");
   a_dsr_irq: assert property ($changed(lvl[1]) |=> int_stat[`UML_SRC_MODEM])
      else $error("data set ready change not latched");
   a_cts_auto: assert property (auto_cts && !int_stat[`UML_SRC_MODEM]
                                && delta_set == 4'h1 ##1 !(wr_ok && wr_idx == `UML_IDX_CTRL)
                                |-> !int_stat[`UML_SRC_MODEM])
      else $error("gated clear-to-send raised modem source");
   a_cts_gate: assert property (auto_cts && !lvl[0] |-> !tx_allowed)
      else $error("transmitter not held by clear-to-send");
   a_dtr_set: assert property (wr_ok && wr_idx == `UML_IDX_MCR && wdata_r[0]
                               && !wdata_r[4] |=> !dtr_n)
      else $error("terminal ready not driven active");
   a_dtr_loop: assert property (loop_mode |-> dtr_n)
      else $error("terminal ready active in loopback");
   a_cs_refuse: assert property (wr_fire && chip_select_active_low
                                 |=> $stable(mcr_r) && $stable(ctrl_r)
                                 && bresp == `UML_RESP_SLVERR)
      else $error("deselected write took effect");
   a_rd_narrow: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_rd_refused: assert property (rd_fire && !rd_ok |=> rdata == 32'h00000000
                                  && rresp == `UML_RESP_SLVERR)
      else $error("refused read returned data");

   property p_reset_out;
      @(posedge aclk) rst |=> dtr_n && !interrupt_request_output;
   endproperty
   a_reset_out: assert property (disable iff (1'b0) p_reset_out)
      else $error("outputs not forced by reset");
endmodule

// File: testbench/uml_modem_model.sv
/*
 * Modem-side partner: drives the four status pins from levels.
 * Assumes the bench gives levels as 1 = active, on one clock.
 */
`timescale 1ns/100ps

module uml_modem_model (
   // Clock
   input  wire logic       aclk,
   // Levels from the bench: cts, dsr, ri, dcd
   input  wire logic [3:0] act,
   // Pins, active low
   output      logic       cts_n,
   output      logic       dsr_n,
   output      logic       ri_n,
   output      logic       dcd_n
);
   logic [3:0] pin_r = 4'hF;

   // Pins move just after an edge, never mid-cycle
   always @(posedge aclk) begin
      pin_r <= ~act;
   end
   assign {dcd_n, ri_n, dsr_n, cts_n} = pin_r;
endmodule

// File: testbench/tb_uml_modem_lines_and_irq.sv
/*
 * Self-checking bench for the modem-line and interrupt block.
 * Assumes uml_top with its AXI4-Lite slave and the modem model.
 */
`timescale 1ns/100ps
`include "uml_consts.svh"

module tb_uml_modem_lines_and_irq;
   import uml_pkg::*;
   localparam logic [7:0] A_STAT = {3'h0, `UML_IDX_INT_STAT, 2'h0};
   localparam logic [7:0] A_EN   = {3'h0, `UML_IDX_INT_EN, 2'h0};
   localparam logic [7:0] A_CLR  = {3'h0, `UML_IDX_INT_CLR, 2'h0};
   localparam logic [7:0] A_CTRL = {3'h0, `UML_IDX_CTRL, 2'h0};
   localparam logic [7:0] A_MCR  = {3'h0, `UML_IDX_MCR, 2'h0};
   localparam logic [7:0] A_MSR  = {3'h0, `UML_IDX_MSR, 2'h0};
   localparam uml_resp_t  OK     = `UML_RESP_OKAY;
   localparam uml_resp_t  ERR    = `UML_RESP_SLVERR;
   localparam int         LIMIT  = 3000;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        mrst = 1'b0;
   logic        cs_n = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic [3:0]  act = 4'h0;
   logic [3:0]  ev = 4'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        dtr_n, tx_allowed, irq;
   logic        cts_n, dsr_n, ri_n, dcd_n;
   uml_resp_t   bresp, rresp;
   logic [31:0] rdata;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   always #2.5 aclk = ~aclk;

   uml_top i_dut (
      .aclk, .aresetn, .master_reset_input(mrst), .chip_select_active_low(cs_n),
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .cts_n, .dsr_n, .ri_n, .dcd_n, .dtr_n,
      .rx_error_evt(ev[0]), .rx_data_evt(ev[1]), .rx_timeout_evt(ev[2]),
      .thr_empty_evt(ev[3]), .tx_allowed, .interrupt_request_output(irq)
   );

   uml_modem_model i_modem (.aclk, .act, .cts_n, .dsr_n, .ri_n, .dcd_n);

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Address and data offered together; bready held until bvalid seen
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input uml_resp_t er);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            chk({30'h0, bresp}, {30'h0, er}, "bresp");
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] ed, input uml_resp_t er);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            chk(rdata, {24'h0, ed}, "rdata");
            chk({30'h0, rresp}, {30'h0, er}, "rresp");
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic pulse(input int e);
      ev[e] <= 1'b1;
      @(posedge aclk);
      ev <= 4'h0;
      @(posedge aclk);
   endtask

   task automatic ck1(input logic got, input logic exp, input string m);
      chk({31'h0, got}, {31'h0, exp}, m);
   endtask

   task automatic settle;
      repeat (6) @(posedge aclk);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      repeat (3) @(posedge aclk);
      ck1(dtr_n, 1'b1, "dtr after reset");
      ck1(irq, 1'b0, "irq after reset");
      rchk(A_MCR, 8'h00, OK);
      rchk(A_CTRL, 8'h00, OK);
      rchk(A_EN, 8'h00, OK);
      rchk(A_MSR, 8'h00, OK);
      $display("t_reset done");
   endtask

   task automatic t_dtr;
      wr(A_MCR, 8'h01, OK);
      ck1(dtr_n, 1'b0, "dtr set");
      rchk(A_MCR, 8'h01, OK);
      wr(A_MCR, 8'h11, OK);
      ck1(dtr_n, 1'b1, "dtr in loop");
      wr(A_MCR, 8'h01, OK);
      ck1(dtr_n, 1'b0, "dtr loop off");
      wr(A_MCR, 8'h00, OK);
      ck1(dtr_n, 1'b1, "dtr cleared");
      $display("t_dtr done");
   endtask

   task automatic t_bus;
      cs_n <= 1'b1;
      wr(A_MCR, 8'h01, ERR);
      ck1(dtr_n, 1'b1, "deselected write");
      rchk(A_MCR, 8'h00, ERR);
      cs_n <= 1'b0;
      // Byte lane 0 not strobed: accepted but no effect
      wstrb <= 4'hE;
      wr(A_MCR, 8'h01, OK);
      ck1(dtr_n, 1'b1, "unstrobed write");
      wstrb <= 4'hF;
      wr(8'h14, 8'h01, ERR);
      wr(8'h30, 8'h01, ERR);
      rchk(8'h1C, 8'h00, ERR);
      rchk(A_CLR, 8'h00, OK);
      rchk(A_MCR, 8'h00, OK);
      $display("t_bus done");
   endtask

   task automatic t_irq;
      logic [7:0] m;
      wr(A_EN, 8'h0F, OK);
      for (int k = 0; k < 3; k++) begin
         m = 8'h01 << k;
         pulse(k == 2 ? 3 : k);
         ck1(irq, 1'b1, "irq raised");
         rchk(A_STAT, m, OK);
         wr(A_CLR, m, OK);
         ck1(irq, 1'b0, "irq serviced");
      end
      pulse(2);
      rchk(A_STAT, 8'h00, OK);
      wr(A_CTRL, 8'h01, OK);
      pulse(2);
      rchk(A_STAT, 8'h02, OK);
      wr(A_EN, 8'h00, OK);
      ck1(irq, 1'b0, "masked");
      wr(A_CLR, 8'h0F, OK);
      wr(A_CTRL, 8'h00, OK);
      $display("t_irq done");
   endtask

   task automatic t_modem;
      wr(A_EN, 8'h08, OK);
      act <= 4'hA;
      settle();
      ck1(irq, 1'b1, "dsr dcd change");
      rchk(A_MSR, 8'hAA, OK);
      rchk(A_MSR, 8'hA0, OK);
      wr(A_CLR, 8'h08, OK);
      act <= 4'hE;
      settle();
      rchk(A_MSR, 8'hE0, OK);
      rchk(A_STAT, 8'h00, OK);
      act <= 4'hA;
      settle();
      rchk(A_MSR, 8'hA4, OK);
      rchk(A_STAT, 8'h08, OK);
      wr(A_CLR, 8'h08, OK);
      $display("t_modem done");
   endtask

   task automatic t_cts;
      wr(A_CTRL, 8'h02, OK);
      ck1(tx_allowed, 1'b0, "tx held");
      act <= 4'hB;
      settle();
      ck1(tx_allowed, 1'b1, "tx allowed");
      rchk(A_STAT, 8'h00, OK);
      rchk(A_MSR, 8'hB1, OK);
      wr(A_CTRL, 8'h00, OK);
      act <= 4'hA;
      settle();
      ck1(irq, 1'b1, "cts change irq");
      rchk(A_MSR, 8'hA1, OK);
      wr(A_CLR, 8'h08, OK);
      $display("t_cts done");
   endtask

   task automatic t_mreset;
      wr(A_MCR, 8'h01, OK);
      wr(A_EN, 8'h01, OK);
      pulse(0);
      ck1(irq, 1'b1, "irq before reset");
      mrst <= 1'b1;
      repeat (2) @(posedge aclk);
      mrst <= 1'b0;
      @(posedge aclk);
      ck1(dtr_n, 1'b1, "dtr master reset");
      ck1(irq, 1'b0, "irq master reset");
      rchk(A_MCR, 8'h00, OK);
      rchk(A_EN, 8'h00, OK);
      $display("t_mreset done");
   endtask

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         close_out();
      end
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_dtr();
      t_bus();
      t_irq();
      t_modem();
      t_cts();
      t_mreset();
      close_out();
   end
endmodule
